// >>> ssp_pkg.sv
// Constants, register map and types of the serial port core
package ssp_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int          SSP_AW          = 3;
  localparam int          SSP_DW          = 8;
  localparam logic [2:0]  ADDR_CTRL0      = 3'h0;  // Clock source and enable
  localparam logic [2:0]  ADDR_CTRL1      = 3'h1;  // serial_control_status
  localparam logic [2:0]  ADDR_DATA       = 3'h2;  // shift_data_register
  localparam logic [2:0]  ADDR_IRQ_STAT   = 3'h3;  // Sticky events, write one to clear
  localparam logic [2:0]  ADDR_IRQ_MASK   = 3'h4;  // Interrupt mask

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CTRL0_SRC_LO    = 5;   // clock_source_select [7:5]
  localparam int          CTRL0_SRC_HI    = 7;
  localparam int          CTRL0_EN        = 1;   // serial_port_enable
  localparam int          CTRL1_POL       = 5;   // clock_polarity_select
  localparam int          CTRL1_EDGE      = 4;   // clock_edge_select
  localparam int          CTRL1_ORDER     = 3;   // bit_order_select, 1 = MSB first
  localparam int          CTRL1_SELEN     = 2;   // select_pin_enable
  localparam int          CTRL1_WCOL      = 1;   // write_collision_flag
  localparam int          CTRL1_DONE      = 0;   // transfer_done_flag
  localparam int          EVT_DONE        = 0;
  localparam int          EVT_WCOL        = 1;
  localparam int          EVT_W           = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  SRC_RESET       = 3'h7;
  localparam logic [7:0]  DATA_RESET      = 8'h00;
  localparam logic [7:0]  READ_ZERO       = 8'h00;

  // ----------------------------------------------------------------
  // Clock source codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  SRC_DIV4        = 3'h0;
  localparam logic [2:0]  SRC_DIV16       = 3'h1;
  localparam logic [2:0]  SRC_DIV64       = 3'h2;
  localparam logic [2:0]  SRC_SUB         = 3'h3;
  localparam logic [2:0]  SRC_TIMER       = 3'h4;
  localparam logic [2:0]  SRC_SLAVE       = 3'h5;

  // ----------------------------------------------------------------
  // Timing: half bit periods in system clocks, less one
  // ----------------------------------------------------------------
  localparam logic [4:0]  HALF_DIV4       = 5'h01;
  localparam logic [4:0]  HALF_DIV16      = 5'h07;
  localparam logic [4:0]  HALF_DIV64      = 5'h1F;
  localparam logic [4:0]  EDGE_LAST       = 5'h0F;  // Sixteen clock edges per byte

  typedef enum logic {SSP_IDLE, SSP_RUN} ssp_state_e;

endpackage

// >>> ssp_clkdiv.sv
// Master bit clock half-period tick generator
`timescale 1ns/1ps
module ssp_clkdiv
  import ssp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [2:0] source_select,
  input  wire logic       sub_clk_in,
  input  wire logic       timer_match,
  output logic            tick
);

  typedef struct packed {
    logic [4:0] cnt;
    logic       sub_prev;
  } ssp_div_s;

  ssp_div_s s;
  ssp_div_s next_s;
  logic     limit_hit;

  // ----------------------------------------------------------------
  // Tick selection
  // ----------------------------------------------------------------
  always_comb begin
    next_s          = s;
    next_s.sub_prev = sub_clk_in;
    limit_hit       = 1'b0;
    case (source_select)
      SRC_DIV4:  limit_hit = (s.cnt == HALF_DIV4);
      SRC_DIV16: limit_hit = (s.cnt == HALF_DIV16);
      SRC_DIV64: limit_hit = (s.cnt == HALF_DIV64);
      default:   limit_hit = 1'b0;
    endcase
    if (!run || limit_hit) begin
      next_s.cnt = 5'h00;
    end else begin
      next_s.cnt = s.cnt + 5'h01;
    end
    case (source_select)
      SRC_SUB:   tick = run && (sub_clk_in != s.sub_prev);  // Each sub clock edge
      SRC_TIMER: tick = run && timer_match;                 // Each timer match
      default:   tick = run && limit_hit;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// >>> ssp_core.sv
// Serial port core: master/slave byte shifter with register port
//
// Behaviour
// - Master mode write to data register starts a full-duplex byte transfer at once.
// - Hardware sets the transfer-done flag at the end of each byte; it can interrupt.
// - Transfer-done flag stays set until software writes it to zero.
// - In slave mode the data register shifts out on external clock edges.
// - In slave mode input bits shift into the data register on those edges.
// - First slave bit is ready relative to select, per polarity and edge choice; the code drives it as soon as the byte is loaded, for every setting.
// - Shifting and flags keep working in the idle power mode.
// - Source field: master at sys/4, /16, /64, sub clock, timer/2; 101 slave.
// - Select pin enable one uses the select pin; zero leaves it floating.
// - Every byte passes through the single shift data register.
`timescale 1ns/1ps
module ssp_core
  import ssp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [SSP_AW-1:0] addr,
  input  wire logic [SSP_DW-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [SSP_DW-1:0] rdata,
  output logic                   irq,
  input  wire logic              sub_clk_in,
  input  wire logic              timer_match,
  input  wire logic              serial_clock_pin_in,
  output logic                   serial_clock_pin_out,
  output logic                   serial_clock_pin_oe,
  input  wire logic              slave_select_n_in,
  output logic                   slave_select_n_out,
  output logic                   slave_select_n_oe,
  input  wire logic              serial_in_pin,
  output logic                   serial_out_pin,
  output logic                   serial_out_pin_oe
);

  typedef struct packed {
    logic [2:0]       src;
    logic             enable;
    logic             polarity;
    logic             edge_sel;
    logic             order;
    logic             sel_en;
    logic             done_flag;
    logic             wcol_flag;
    logic [7:0]       shreg;
    logic             rx_hold;
    logic [4:0]       cnt;
    ssp_state_e       state;
    logic             ss_n_o;
    logic             sck_o;
    logic             sclk_prev;
    logic [EVT_W-1:0] evt_stat;
    logic [EVT_W-1:0] evt_mask;
    logic [7:0]       rdata;
  } ssp_core_s;

  ssp_core_s s;
  ssp_core_s next_s;

  logic       is_master;
  logic       is_slave;
  logic       selected;
  logic       tick;
  logic       bit_edge;
  logic       capture;
  logic       busy;
  logic       data_wr;
  logic       done_pulse;
  logic       wcol_pulse;
  logic [7:0] ctrl0_rd;
  logic [7:0] ctrl1_rd;

  // ----------------------------------------------------------------
  // Byte shift helper
  // ----------------------------------------------------------------
  function automatic logic [7:0] shift_byte(input logic [7:0] v, input logic msb_first,
                                            input logic in_bit);
    if (msb_first) begin
      shift_byte = {v[6:0], in_bit};
    end else begin
      shift_byte = {in_bit, v[7:1]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Codes 110 and 111 leave the port inert
  assign is_master = s.enable && (s.src <= SRC_TIMER);
  assign is_slave  = s.enable && (s.src == SRC_SLAVE);
  // Slave listens always when the select pin is disabled
  assign selected  = !s.sel_en || !slave_select_n_in;
  assign busy      = (s.state == SSP_RUN) || (s.cnt != 5'h00);
  assign data_wr   = wr && (addr == ADDR_DATA);

  // Bit clock source; no gating by the idle power mode
  ssp_clkdiv u_clkdiv (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .run           (is_master && (s.state == SSP_RUN)),
    .source_select (s.src),
    .sub_clk_in    (sub_clk_in),
    .timer_match   (timer_match),
    .tick          (tick)
  );

  // Readback images
  assign ctrl0_rd = {s.src, 3'h0, s.enable, 1'b0};
  assign ctrl1_rd = {2'h0, s.polarity, s.edge_sel, s.order, s.sel_en,
                     s.wcol_flag, s.done_flag};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s     = s;
    done_pulse = 1'b0;
    wcol_pulse = 1'b0;
    // Master edges come from the divider, slave edges from the pin
    bit_edge   = (is_master && (s.state == SSP_RUN) && tick) ||
                 (is_slave && selected && (serial_clock_pin_in != s.sclk_prev));
    // Even edge count means leading edge; edge_sel one captures there
    capture    = (!s.cnt[0]) == s.edge_sel;
    next_s.sclk_prev = serial_clock_pin_in;

    // Idle clock level follows polarity
    if (s.state == SSP_IDLE) begin
      next_s.sck_o = !s.polarity;
    end

    // Shift engine
    if (bit_edge) begin
      if (is_master) begin
        next_s.sck_o = !s.sck_o;
      end
      if (capture) begin
        next_s.rx_hold = serial_in_pin;
      end else if (s.cnt != 5'h00) begin
        next_s.shreg = shift_byte(s.shreg, s.order, s.rx_hold);
      end
      if (s.cnt == EDGE_LAST) begin
        if (capture) begin
          next_s.shreg = shift_byte(s.shreg, s.order, serial_in_pin);
        end
        next_s.cnt    = 5'h00;
        next_s.state  = SSP_IDLE;
        next_s.ss_n_o = 1'b1;
        done_pulse    = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 5'h01;
      end
    end

    // Slave drop of select abandons a partial byte
    if (is_slave && !selected) begin
      next_s.cnt = 5'h00;
    end

    // Software access to the data register
    if (data_wr) begin
      if (busy) begin
        wcol_pulse = 1'b1;
      end else begin
        next_s.shreg = wdata;
        if (is_master) begin
          next_s.state  = SSP_RUN;
          next_s.cnt    = 5'h00;
          next_s.ss_n_o = 1'b0;
          next_s.sck_o  = !s.polarity;
        end
      end
    end

    // Disabling, or leaving master mode, aborts any transfer
    if (!s.enable || (!is_master && (s.state == SSP_RUN))) begin
      next_s.state  = SSP_IDLE;
      next_s.cnt    = 5'h00;
      next_s.ss_n_o = 1'b1;
    end

    // Control register writes
    if (wr && (addr == ADDR_CTRL0)) begin
      next_s.src    = wdata[CTRL0_SRC_HI:CTRL0_SRC_LO];
      next_s.enable = wdata[CTRL0_EN];
    end
    if (wr && (addr == ADDR_CTRL1)) begin
      next_s.polarity  = wdata[CTRL1_POL];
      next_s.edge_sel  = wdata[CTRL1_EDGE];
      next_s.order     = wdata[CTRL1_ORDER];
      next_s.sel_en    = wdata[CTRL1_SELEN];
      // Flags clear only by writing zero
      next_s.done_flag = s.done_flag && wdata[CTRL1_DONE];
      next_s.wcol_flag = s.wcol_flag && wdata[CTRL1_WCOL];
    end
    // Hardware set wins over a same-cycle clear
    if (done_pulse) begin
      next_s.done_flag = 1'b1;
    end
    if (wcol_pulse) begin
      next_s.wcol_flag = 1'b1;
    end

    // Interrupt status and mask
    if (wr && (addr == ADDR_IRQ_STAT)) begin
      next_s.evt_stat = s.evt_stat & ~wdata[EVT_W-1:0];
    end
    if (wr && (addr == ADDR_IRQ_MASK)) begin
      next_s.evt_mask = wdata[EVT_W-1:0];
    end
    next_s.evt_stat[EVT_DONE] = next_s.evt_stat[EVT_DONE] || done_pulse;
    next_s.evt_stat[EVT_WCOL] = next_s.evt_stat[EVT_WCOL] || wcol_pulse;

    // Read data, valid the cycle after the strobe
    next_s.rdata = READ_ZERO;
    if (rd) begin
      case (addr)
        ADDR_CTRL0:    next_s.rdata = ctrl0_rd;
        ADDR_CTRL1:    next_s.rdata = ctrl1_rd;
        ADDR_DATA:     next_s.rdata = s.shreg;
        ADDR_IRQ_STAT: next_s.rdata = {6'h00, s.evt_stat};
        ADDR_IRQ_MASK: next_s.rdata = {6'h00, s.evt_mask};
        default:       next_s.rdata = READ_ZERO;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s          <= '0;
      s.src      <= SRC_RESET;
      s.shreg    <= DATA_RESET;
      s.state    <= SSP_IDLE;
      s.ss_n_o   <= 1'b1;
      s.sck_o    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata                = s.rdata;
  assign irq                  = |(s.evt_stat & s.evt_mask);
  assign serial_clock_pin_out = s.sck_o;
  assign serial_clock_pin_oe  = is_master;
  assign slave_select_n_out   = s.ss_n_o;
  assign slave_select_n_oe    = is_master && s.sel_en;
  // First bit sits on the line as soon as the byte is loaded
  assign serial_out_pin       = s.order ? s.shreg[7] : s.shreg[0];
  assign serial_out_pin_oe    = is_master || (is_slave && selected);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_start_on_write: assert property (
    @(posedge ref_clk) disable iff (reset)
    (data_wr && is_master && !busy) |=> (s.state == SSP_RUN) && !s.ss_n_o)
    else $error("master write did not start a transfer");

  a_done_sets_flag: assert property (
    @(posedge ref_clk) disable iff (reset)
    done_pulse |=> s.done_flag && s.evt_stat[EVT_DONE])
    else $error("transfer end did not set the done flag");

  a_done_sticky: assert property (
    @(posedge ref_clk) disable iff (reset)
    (s.done_flag && !(wr && (addr == ADDR_CTRL1) && !wdata[CTRL1_DONE])) |=> s.done_flag)
    else $error("done flag cleared without a zero write");

  a_slave_drives_out: assert property (
    @(posedge ref_clk) disable iff (reset)
    is_slave |-> (serial_out_pin_oe == selected) && !serial_clock_pin_oe)
    else $error("slave output enable wrong");

  a_slave_capture: assert property (
    @(posedge ref_clk) disable iff (reset)
    (is_slave && bit_edge && capture) |=> (s.rx_hold == $past(serial_in_pin)))
    else $error("slave did not capture the input bit");

  a_select_before_clk: assert property (
    @(posedge ref_clk) disable iff (reset)
    (is_master && $changed(s.sck_o) && $past(s.state) == SSP_RUN) |-> !$past(s.ss_n_o))
    else $error("master clock toggled with select high");

  a_first_bit_ready: assert property (
    @(posedge ref_clk) disable iff (reset)
    (data_wr && !busy) |=> serial_out_pin == (s.order ? $past(wdata[7]) : $past(wdata[0])))
    else $error("first bit not ready after load");

  a_byte_length: assert property (
    @(posedge ref_clk) disable iff (reset)
    $rose(s.state == SSP_RUN) |-> (s.cnt == 5'h00))
    else $error("transfer started with a stale edge count");

  a_slave_no_clock: assert property (
    @(posedge ref_clk) disable iff (reset)
    (s.enable && s.src == SRC_SLAVE) |-> !serial_clock_pin_oe && (s.state == SSP_IDLE))
    else $error("slave mode drives the clock");

  a_select_float: assert property (
    @(posedge ref_clk) disable iff (reset)
    !s.sel_en |-> !slave_select_n_oe)
    else $error("select pin driven while disabled");

  a_collision_flag: assert property (
    @(posedge ref_clk) disable iff (reset)
    (data_wr && busy && !bit_edge) |=> s.wcol_flag && $stable(s.shreg))
    else $error("busy write not flagged or not ignored");

endmodule

// >>> ssp_partner.sv
// Serial slave model that faces the core in master mode
`timescale 1ns/1ps
module ssp_partner (
  input  wire logic       ref_clk,
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic       pol,
  input  wire logic       edg,
  input  wire logic       msb,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic      [7:0] rx,
  output logic            viol
);
  logic       sck_q = 1'h0;
  logic       ss_q  = 1'h1;
  logic       flip  = 1'h0;
  logic       mosi_q = 1'h0;
  logic [3:0] nsh   = 4'h0;
  logic [2:0] idx;

  initial rx = 8'h00;
  initial viol = 1'h0;

  // Bit on offer: first one ready at select, later ones after shift edges
  assign idx  = (edg || nsh == 4'h0) ? nsh[2:0] : nsh[2:0] - 3'h1;
  assign miso = ss_n ? flip : (msb ? tx[3'h7 - idx] : tx[idx]);

  // Edge follower; released data line toggles every cycle
  always @(posedge ref_clk) begin
    sck_q <= sck;
    ss_q  <= ss_n;
    flip  <= ~flip;
    mosi_q <= mosi;
    if (ss_n)
      nsh <= 4'h0;
    if (ss_q && !ss_n && sck != !pol)
      viol <= 1'h1;
    // Edge is seen a cycle late: use select and data as they stood at it
    if (sck != sck_q && !ss_q) begin
      if (sck == (edg ? pol : !pol))
        rx <= msb ? {rx[6:0], mosi_q} : {mosi_q, rx[7:1]};
      else
        nsh <= nsh + 4'h1;
    end
  end
endmodule

// >>> test_spi_serial_port_core.sv
// Self-checking bench of the serial port core with a slave model
`timescale 1ns/1ps
module test_spi_serial_port_core import ssp_pkg::*;;
  logic        ref_clk = 1'h0;
  logic        reset = 1'h1;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        rd_q = 1'h0;
  logic [7:0]  rdata;
  logic        irq;
  logic        sub_clk = 1'h0;
  logic        tmatch = 1'h0;
  logic        sck_o, sck_oe, ss_o, ss_oe, sdo, sdo_oe, viol, p_miso;
  logic        tb_sck = 1'h0, tb_ss_n = 1'h1, tb_sdi = 1'h0, slave = 1'h0;
  logic        pol = 1'h1, edg = 1'h1, msb = 1'h1;
  logic [7:0]  ptx = 8'h00, p_rx;
  logic [7:0]  exp_q[$];
  string       nam_q[$];
  int          n_errors = 0, comparisons = 0, tick = 0;
  wire         sck_ln = sck_oe ? sck_o : tb_sck;
  wire         ss_ln = ss_oe ? ss_o : tb_ss_n; // Pull-up when floating
  wire         sdi = slave ? tb_sdi : p_miso;

  initial forever #2 ref_clk = ~ref_clk;

  ssp_core dut (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .sub_clk_in(sub_clk),
    .timer_match(tmatch), .serial_clock_pin_in(sck_ln),
    .serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe),
    .slave_select_n_in(ss_ln), .slave_select_n_out(ss_o),
    .slave_select_n_oe(ss_oe), .serial_in_pin(sdi), .serial_out_pin(sdo),
    .serial_out_pin_oe(sdo_oe));

  ssp_partner slv (.ref_clk(ref_clk), .sck(sck_ln), .ss_n(ss_ln), .mosi(sdo),
    .pol(pol), .edg(edg), .msb(msb), .tx(ptx), .miso(p_miso), .rx(p_rx),
    .viol(viol));

  // Sub clock toggles every third cycle, timer match every fifth
  always @(posedge ref_clk) begin
    tick <= tick + 1;
    sub_clk <= (tick % 3 == 0) ? ~sub_clk : sub_clk;
    tmatch <= (tick % 5 == 0);
  end

  // Read data monitor: oldest note against the cycle after the strobe
  always @(posedge ref_clk) begin
    rd_q <= rd;
    if (rd_q && exp_q.size() > 0)
      check(nam_q.pop_front(), rdata, exp_q.pop_front());
  end

  // ----------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge ref_clk);
    wr <= 1'h0;
    #1;
  endtask

  task automatic rreg(input string what, input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'h1;
    exp_q.push_back(e);
    nam_q.push_back(what);
    @(posedge ref_clk);
    rd <= 1'h0;
    #1;
  endtask

  task automatic wait_irq();
    int n;
    for (n = 0; n < 3000 && irq !== 1'h1; n++)
      @(posedge ref_clk);
    if (n == 3000) begin
      n_errors++;
      $display("MISMATCH irq expected 1 seen %b", irq);
      stop_test();
    end
  endtask

  // One master byte with the slave model, flags checked and cleared
  task automatic xfer(input logic [2:0] src, input logic [7:0] c1, input logic coll);
    logic [7:0] tx;
    tx = 8'($urandom);
    ptx = 8'($urandom);
    pol = c1[CTRL1_POL];
    edg = c1[CTRL1_EDGE];
    msb = c1[CTRL1_ORDER];
    wreg(ADDR_CTRL0, {src, 5'h02});
    wreg(ADDR_CTRL1, c1);
    wreg(ADDR_DATA, tx);
    if (coll)
      wreg(ADDR_DATA, ~tx);
    wait_irq();
    repeat (20) @(posedge ref_clk);
    rreg("data", ADDR_DATA, ptx);
    rreg("status", ADDR_CTRL1, c1 | {6'h00, coll, 1'h1});
    rreg("events", ADDR_IRQ_STAT, {6'h00, coll, 1'h1});
    check("slave rx", p_rx, tx);
    wreg(ADDR_IRQ_MASK, 8'h00);
    check("masked irq", {7'h00, irq}, 8'h00);
    wreg(ADDR_IRQ_MASK, 8'h01);
    check("irq", {7'h00, irq}, 8'h01);
    wreg(ADDR_IRQ_STAT, 8'h03);
    check("irq off", {7'h00, irq}, 8'h00);
    wreg(ADDR_CTRL1, c1);
    rreg("cleared", ADDR_CTRL1, c1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int s;
    logic [7:0] d;
    logic [7:0] m;
    s = $urandom(32'hB38726A3);
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    rreg("ctrl0", ADDR_CTRL0, 8'hE0);
    rreg("ctrl1", ADDR_CTRL1, 8'h00);
    rreg("data", ADDR_DATA, DATA_RESET);
    wreg(3'h5, 8'hFF);
    rreg("unmapped", 3'h5, READ_ZERO);
    wreg(ADDR_CTRL1, 8'hFF);
    rreg("ctrl1 rw", ADDR_CTRL1, 8'h3C);
    wreg(ADDR_CTRL0, 8'hFF);
    rreg("ctrl0 rw", ADDR_CTRL0, 8'hE2);
    wreg(ADDR_IRQ_MASK, 8'h01);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
      xfer(SRC_DIV4, {2'h0, 3'(i), 3'h4}, i == 3);
    xfer(SRC_DIV16, 8'h3C, 1'h0);
    xfer(SRC_DIV64, 8'h2C, 1'h1);
    xfer(SRC_SUB, 8'h3C, 1'h0);
    xfer(SRC_TIMER, 8'h1C, 1'h0);
    $display("test master done");
    wreg(ADDR_CTRL1, 8'h38);
    wreg(ADDR_DATA, 8'h5A);
    repeat (4) @(posedge ref_clk);
    #1;
    check("select oe", {7'h00, ss_oe}, 8'h00);
    check("clock oe", {7'h00, sck_oe}, 8'h01);
    wait_irq();
    wreg(ADDR_IRQ_STAT, 8'h03);
    wreg(ADDR_CTRL0, 8'hC2);
    wreg(ADDR_DATA, 8'hA5);
    repeat (40) @(posedge ref_clk);
    rreg("inert", ADDR_IRQ_STAT, 8'h00);
    check("inert oe", {7'h00, sck_oe}, 8'h00);
    $display("test select done");
    d = 8'($urandom);
    m = 8'($urandom);
    slave = 1'h1;
    pol = 1'h1; // Model also sees the bench's select and clock, idle low
    wreg(ADDR_CTRL0, 8'hA2);
    wreg(ADDR_CTRL1, 8'h3C);
    wreg(ADDR_DATA, d);
    @(posedge ref_clk);
    tb_ss_n <= 1'h0;
    for (int b = 7; b >= 0; b--) begin
      tb_sdi <= m[b];
      repeat (4) @(posedge ref_clk);
      #1;
      check("slave out", {7'h00, sdo}, {7'h00, d[b]});
      check("slave oe", {7'h00, sdo_oe}, 8'h01);
      @(posedge ref_clk);
      tb_sck <= 1'h1;
      repeat (4) @(posedge ref_clk);
      tb_sck <= 1'h0;
    end
    repeat (4) @(posedge ref_clk);
    tb_ss_n <= 1'h1;
    tb_sdi <= ~tb_sdi;
    wait_irq();
    rreg("slave data", ADDR_DATA, m);
    check("idle clock", {7'h00, viol}, 8'h00);
    check("released oe", {7'h00, sdo_oe}, 8'h00);
    $display("test slave done");
    repeat (4) @(posedge ref_clk);
    stop_test();
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
endmodule
